// [design/srst_ctrl.v]
// Behaviour
// - Self-test register bit 0 set enables self-test mode; clear disables it.
// - Self-test register bit 1 set applies the self-test force; clear removes it.
// - Writing 0x52 to write-only reset register starts full power-on style reset.
// - After any reset, factory trim is copied into shadow registers used by logic.
//
// The implementer's own choice: the plain strobed port.
`include "srst_defs.vh"
`default_nettype none
module srst_ctrl #(
	parameter HOLD_CYCLES = `SRST_HOLD_CYCLES,
	parameter COUNT = `SRST_SHADOW_COUNT,
	parameter [39:0] TRIM_VALUES = 40'h0403020100
) (
	input wire clock,
	input wire rst_n,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	output reg [7:0] rdata,
	output reg self_test_mode_enable,
	output reg self_test_force_enable,
	output reg device_reset,
	output reg trim_loaded
);
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam [2:0] ST_HOLD = 3'b001;
	localparam [2:0] ST_LOAD = 3'b010;
	localparam [2:0] ST_RUN = 3'b100;
	localparam IDX_W = 3;
	localparam [3:0] HOLD_LAST = HOLD_CYCLES - 1;
	localparam [IDX_W-1:0] LAST_IDX = COUNT - 1;

	// ----------------------------------------
	// State and decode signals
	// ----------------------------------------
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [3:0] hold_reg;
	reg [3:0] hold_next;
	reg [IDX_W-1:0] idx_reg;
	reg [IDX_W-1:0] idx_next;
	reg [7:0] st_reg;
	reg [7:0] st_next;
	reg [7:0] rdata_next;
	reg device_reset_next;
	reg trim_loaded_next;
	wire in_hold;
	wire in_load;
	wire in_run;
	wire sel_self_test;
	wire sel_soft_reset;
	wire sel_load_status;
	wire in_shadow;
	wire wr_self_test;
	wire wr_soft_reset;
	wire soft_reset_hit;
	wire [7:0] shadow_off;
	wire [7:0] trim_data;
	wire [7:0] shadow_data;
	wire [IDX_W-1:0] rd_idx;

	// ----------------------------------------
	// State and address decode
	// ----------------------------------------
	assign in_hold = state_reg == ST_HOLD;
	assign in_load = state_reg == ST_LOAD;
	assign in_run = state_reg == ST_RUN;
	assign sel_self_test = addr == `SRST_ADDR_SELF_TEST;
	assign sel_soft_reset = addr == `SRST_ADDR_SOFT_RESET;
	assign sel_load_status = addr == `SRST_ADDR_LOAD_STATUS;
	assign in_shadow = addr >= `SRST_ADDR_SHADOW_FIRST && addr <= `SRST_ADDR_SHADOW_LAST;
	assign wr_self_test = wr_en && sel_self_test;
	assign wr_soft_reset = wr_en && sel_soft_reset;
	// Other values on the reset register stop here and never reach the sequencer
	assign soft_reset_hit = wr_soft_reset && wdata == `SRST_RESET_CODE;
	assign shadow_off = addr - `SRST_ADDR_SHADOW_FIRST;
	assign rd_idx = in_shadow ? shadow_off[IDX_W-1:0] : {IDX_W{1'b0}};

	srst_trim_store #(
		.IDX_W(IDX_W),
		.TRIM_VALUES(TRIM_VALUES)
	) u_trim (
		.idx(idx_reg),
		.data(trim_data)
	);

	srst_shadow_bank #(
		.COUNT(COUNT),
		.IDX_W(IDX_W)
	) u_shadow (
		.clock(clock),
		.rst_n(rst_n),
		.load_en(state_reg == ST_LOAD),
		.load_idx(idx_reg),
		.load_data(trim_data),
		.rd_idx(rd_idx),
		.rd_data(shadow_data)
	);

	// ----------------------------------------
	// Reset and reload sequencer
	// ----------------------------------------
	// Soft reset re-enters the same path as power-on, so both reload trim alike
	// The reset code wins in every state, so a reload cut short starts over cleanly
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_HOLD:
			begin
				if (hold_reg == 4'h0)
				begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD:
			begin
				if (idx_reg == LAST_IDX)
				begin
					state_next = ST_RUN;
				end
			end
			ST_RUN:
			begin
				state_next = ST_RUN;
			end
			default:
			begin
				state_next = ST_HOLD;
			end
		endcase
		if (soft_reset_hit)
		begin
			state_next = ST_HOLD;
		end
	end

	always @*
	begin
		hold_next = hold_reg;
		if (soft_reset_hit || !in_hold)
		begin
			hold_next = HOLD_LAST;
		end
		else if (hold_reg != 4'h0)
		begin
			hold_next = hold_reg - 4'h1;
		end
	end

	always @*
	begin
		idx_next = {IDX_W{1'b0}};
		if (in_load && state_next == ST_LOAD)
		begin
			idx_next = idx_reg + 3'h1;
		end
	end

	always @*
	begin
		device_reset_next = 1'b1;
		trim_loaded_next = 1'b0;
		if (state_next == ST_RUN)
		begin
			device_reset_next = 1'b0;
			trim_loaded_next = 1'b1;
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_HOLD;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			hold_reg <= HOLD_LAST;
		end
		else
		begin
			hold_reg <= hold_next;
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			idx_reg <= {IDX_W{1'b0}};
		end
		else
		begin
			idx_reg <= idx_next;
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			device_reset <= 1'b1;
			trim_loaded <= 1'b0;
		end
		else
		begin
			device_reset <= device_reset_next;
			trim_loaded <= trim_loaded_next;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Self-test bits fall back to zero on soft reset, like power-on
	// Self-test writes during reload are dropped, not queued: software waits for the load flag
	always @*
	begin
		st_next = st_reg;
		if (!in_run)
		begin
			st_next = `SRST_SELF_TEST_RESET;
		end
		else if (wr_self_test)
		begin
			st_next = {6'h00, wdata[1:0]};
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			st_reg <= `SRST_SELF_TEST_RESET;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			self_test_mode_enable <= 1'b0;
			self_test_force_enable <= 1'b0;
		end
		else
		begin
			self_test_mode_enable <= st_reg[`SRST_BIT_MODE_ENABLE];
			self_test_force_enable <= st_reg[`SRST_BIT_FORCE_ENABLE];
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Read data stand for one cycle only and then return to zero
	always @*
	begin
		rdata_next = 8'h00;
		if (!rd_en)
		begin
			rdata_next = 8'h00;
		end
		else if (sel_self_test)
		begin
			rdata_next = st_reg;
		end
		else if (sel_soft_reset)
		begin
			rdata_next = `SRST_SOFT_RESET_VALUE;
		end
		else if (in_shadow)
		begin
			rdata_next = shadow_data;
		end
		else if (sel_load_status)
		begin
			rdata_next = {7'h00, trim_loaded};
		end
		else
		begin
			rdata_next = 8'h00;
		end
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			rdata <= 8'h00;
		end
		else
		begin
			rdata <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// [common/srst_defs.vh]
`ifndef SRST_DEFS_VH
`define SRST_DEFS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define SRST_ADDR_W 8
`define SRST_ADDR_SELF_TEST 8'h2e
`define SRST_ADDR_SOFT_RESET 8'h2f
`define SRST_ADDR_SHADOW_FIRST 8'h50
`define SRST_ADDR_SHADOW_LAST 8'h54
`define SRST_ADDR_LOAD_STATUS 8'h55
`define SRST_SHADOW_COUNT 5
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define SRST_BIT_MODE_ENABLE 0
`define SRST_BIT_FORCE_ENABLE 1
`define SRST_SELF_TEST_RESET 8'h00
`define SRST_SOFT_RESET_VALUE 8'h00
`define SRST_RESET_CODE 8'h52
`define SRST_SHADOW_RESET 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define SRST_HOLD_CYCLES 4
`endif

// [design/srst_shadow_bank.v]
`include "srst_defs.vh"
`default_nettype none
// ----------------------------------------
// Shadow registers, loaded one entry per cycle
// ----------------------------------------
module srst_shadow_bank #(
	parameter COUNT = `SRST_SHADOW_COUNT,
	parameter IDX_W = 3
) (
	input wire clock,
	input wire rst_n,
	input wire load_en,
	input wire [IDX_W-1:0] load_idx,
	input wire [7:0] load_data,
	input wire [IDX_W-1:0] rd_idx,
	output wire [7:0] rd_data
);
	wire [8*COUNT-1:0] flat;
	genvar g;
	generate
		for (g = 0; g < COUNT; g = g + 1)
		begin : entry
			reg [7:0] value_reg;
			always @(posedge clock)
			begin
				if (!rst_n)
					value_reg <= `SRST_SHADOW_RESET;
				else if (load_en && load_idx == g)
					value_reg <= load_data;
			end
			assign flat[8*g+7:8*g] = value_reg;
		end
	endgenerate
	assign rd_data = (rd_idx < COUNT) ? flat[8*rd_idx +: 8] : 8'h00;
endmodule
`default_nettype wire

// [design/srst_trim_store.v]
`include "srst_defs.vh"
`default_nettype none
// ----------------------------------------
// Factory trim store: read-only constants
// ----------------------------------------
module srst_trim_store #(
	parameter IDX_W = 3,
	parameter [39:0] TRIM_VALUES = 40'h0403020100
) (
	input wire [IDX_W-1:0] idx,
	output wire [7:0] data
);
	// Trim contents are arbitrary defaults; a real part programs them at test
	assign data = (idx < 5) ? TRIM_VALUES[8*idx +: 8] : 8'h00;
endmodule
`default_nettype wire

// [bench/srst_properties.sv]
`default_nettype none
module srst_props(
	input wire clock,
	input wire rst_n,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] rdata,
	input wire self_test_mode_enable,
	input wire self_test_force_enable,
	input wire device_reset,
	input wire trim_loaded
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire st_wr = wr_en && addr == 8'h2e && trim_loaded;
	wire rs_wr = wr_en && addr == 8'h2f;
	property p_mode; st_wr |-> ##2 self_test_mode_enable == $past(wdata[0], 2); endproperty
	a_mode: assert property (p_mode) else $error("mode bit");
	property p_force; st_wr |-> ##2 self_test_force_enable == $past(wdata[1], 2); endproperty
	a_force: assert property (p_force) else $error("force bit");
	property p_rst; rs_wr && wdata == 8'h52 |=> device_reset && !trim_loaded; endproperty
	a_rst: assert property (p_rst) else $error("no reset");
	property p_load; $rose(device_reset) |-> !trim_loaded [*8] ##[1:20] trim_loaded && !device_reset; endproperty
	a_load: assert property (p_load) else $error("reload");
	property p_ign; rs_wr && wdata != 8'h52 && trim_loaded |=> trim_loaded; endproperty
	a_ign: assert property (p_ign) else $error("bad code acted");
	property p_rz; rd_en && addr == 8'h2f |=> rdata == 8'h00; endproperty
	a_rz: assert property (p_rz) else $error("reset reg read");
endmodule
`default_nettype wire

// [bench/srst_host.sv]
`default_nettype none
module srst_host #(parameter logic [39:0] TRIM = 40'h0)(
	input wire clock,
	input wire [7:0] rdata,
	input wire trim_loaded,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	output logic wr_en,
	output logic rd_en
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] exp_q[$];
	logic [7:0] ref_val[5];
	initial {addr, wdata, wr_en, rd_en} = '0;
	// Idle edge after each strobe keeps a driver from assigning it twice at one edge
	task wr(input logic [7:0] a, d);
		{addr, wdata, wr_en} <= {a, d, 1'b1};
		@(posedge clock);
		{addr, wr_en} <= {~a, 1'b0};
		@(posedge clock);
	endtask
	task rd(input logic [7:0] a, e, output logic [7:0] d);
		exp_q.push_back(e);
		{addr, rd_en} <= {a, 1'b1};
		@(posedge clock);
		{addr, rd_en} <= {~a, 1'b0};
		@(posedge clock);
		d = rdata;
	endtask
	task capture;
		for (int i = 0; i < 5; i++) rd(8'h50 + i[7:0], TRIM[8*i +: 8], ref_val[i]);
	endtask
	task soft_reset(output int tries);
		logic [7:0] v;
		logic same;
		tries = 0;
		do
		begin
			wr(8'h2f, 8'h52);
			tries++;
			for (int n = 0; n < 30 && trim_loaded !== 1'b1; n++) @(posedge clock);
			same = 1'b1;
			for (int i = 0; i < 5; i++)
			begin
				rd(8'h50 + i[7:0], TRIM[8*i +: 8], v);
				same &= v === ref_val[i];
			end
		end
		while (!same && tries < 4);
	endtask
endmodule
`default_nettype wire

// [bench/tb_srst_ctrl.sv]
`default_nettype none
module tb_srst_ctrl;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [39:0] TRIM = 40'h5a3c0f81e7;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic rd_seen = 1'b0;
	logic [7:0] addr, wdata, rdata, v;
	logic wr_en, rd_en, self_test_mode_enable, self_test_force_enable, device_reset, trim_loaded;
	int fail_count = 0;
	int n_compared = 0;
	int tries;
	srst_ctrl #(.TRIM_VALUES(TRIM)) dut (.*);
	srst_host #(.TRIM(TRIM)) host (.*);
	initial forever #5 clock = ~clock;
	task chk(input string s, input logic [7:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Read data stand only one cycle, so compare at the falling edge in between
	always @(posedge clock) rd_seen <= rd_en;
	always @(negedge clock)
		if (rd_seen)
			chk("rdata", host.exp_q.pop_front(), rdata);
	initial
	begin
		#20000;
		fail_count++;
		final_report;
	end
	initial
	begin
		void'($urandom(32'hf2a4));
		repeat (6) @(posedge clock);
		chk("held", 8'h01, {7'h0, device_reset});
		rst_n <= 1'b1;
		host.rd(8'h55, 8'h00, v);
		host.wr(8'h2e, 8'h03);
		for (int n = 0; n < 30 && trim_loaded !== 1'b1; n++) @(posedge clock);
		chk("boot", 8'h01, {7'h0, trim_loaded});
		chk("refused", 8'h00, {6'h0, self_test_force_enable, self_test_mode_enable});
		host.capture;
		$display("boot test done");
		for (int c = 0; c < 4; c++)
		begin
			host.wr(8'h2e, c[7:0]);
			@(posedge clock);
			chk("selftest", c[7:0], {6'h0, self_test_force_enable, self_test_mode_enable});
			host.rd(8'h2e, c[7:0], v);
		end
		$display("self test done");
		repeat (4)
		begin
			v = 8'($urandom);
			host.wr(8'h2f, v == 8'h52 ? 8'h00 : v);
			chk("ignored", 8'h03, {6'h0, self_test_force_enable, trim_loaded});
		end
		host.rd(8'h2f, 8'h00, v);
		host.rd(8'h33, 8'h00, v);
		$display("reset code test done");
		host.soft_reset(tries);
		chk("tries", 8'h01, tries[7:0]);
		chk("cleared", 8'h00, {6'h0, self_test_force_enable, self_test_mode_enable});
		host.rd(8'h2e, 8'h00, v);
		host.rd(8'h55, 8'h01, v);
		$display("soft reset test done");
		final_report;
	end
endmodule
bind srst_ctrl srst_props props (.*);
`default_nettype wire
